// ### core/owd_defines.vh
// Purpose: Constants for the option word decoder
// Assumes: 13-bit option words, AXI4-Lite register access
// Notes: Offsets are byte addresses on the register bus
`ifndef OWD_DEFINES_VH
`define OWD_DEFINES_VH
`define OWD_WORD_W 13
`define OWD_OFF_FIRST 4'h0
`define OWD_OFF_SECOND 4'h4
`define OWD_OFF_STATUS 4'h8
`define OWD_OFF_CTRL 4'hc
`define OWD_FIRST_FILL 13'h1c00
`define OWD_SECOND_FILL 13'h1e00
`define OWD_FIRST_RST 13'h1fff
`define OWD_SECOND_RST 13'h1fff
`define OWD_F_PERIOD 8
`define OWD_F_WDOG 7
`define OWD_F_OSC_HI 6
`define OWD_F_OSC_LO 4
`define OWD_F_POWER 3
`define OWD_F_PROT_HI 2
`define OWD_F_FWIDTH 8
`define OWD_F_FEN 7
`define OWD_F_BRANCH 6
`define OWD_F_CAL_HI 5
`define OWD_F_CAL_LO 2
`define OWD_F_IRC_HI 1
`define OWD_OSC_EXT_RC_IO 3'h0
`define OWD_OSC_EXT_RC_CK 3'h1
`define OWD_OSC_INT_RC_IO 3'h2
`define OWD_OSC_INT_RC_CK 3'h3
`define OWD_OSC_LOW_XTAL 3'h6
`define OWD_OSC_HIGH_XTAL 3'h7
`define OWD_PROT_OFF 3'h7
`define OWD_FWIDTH_SHORT 6'h08
`define OWD_FWIDTH_LONG 6'h20
`define OWD_RESP_OKAY 2'h0
`define OWD_RESP_SLVERR 2'h2
`endif

// ### core/owd_option_decoder.v
// Purpose: Latch and decode the two option words into core settings
// Assumes: Option words are stable while reset is held
// Notes: Registers readable over AXI4-Lite; all are read only
//
// What this block does
// R1: Two 13-bit option words and an ID word, outside program memory.
// R2: Upper bits 12..10 of the first word and 12..9 of the second always hold and read as one.
// R3: First word bit 8 picks two or four oscillator periods.
// R4: First word bit 7 low enables watchdog, high disables it.
// R5: First word bits 6..4 pick the oscillator mode.
// R6: Internal RC frees the oscillator input; external RC uses it.
// R7: Crystal modes reserve both oscillator pins from general I/O.
// R8: First word bit 3 picks low or high power range.
// R9: Protect bits enable protection unless all three are one.
// R10: Interrupt pin triggers on a falling edge.
// R11: Second word bit 8 picks 8 or 32 clock noise filter.
// R12: Second word bit 7 enables interrupt noise rejection.
// R13: Noise rejection is off in low crystal mode and in sleep.
// R14: Second word bit 6 picks one or two instruction cycles.
// R15: Programmer must store ones in the four calibration bits.
// R16: Second word bits 1..0 pick the internal RC frequency.
// R17: Only program counter writes take the selected cycle count.
// R18: Settings are captured during reset and held afterwards.
`timescale 1ns/100ps
`include "owd_defines.vh"

module owd_option_decoder
(
  input wire core_clk_i,
  input wire rstn_i,
  input wire [12:0] first_word_i,
  input wire [12:0] second_word_i,
  input wire [12:0] id_word_i,
  input wire sleep_i,
  input wire pc_write_i,
  input wire [3:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output wire s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output wire s_axi_wready_o,
  output wire [1:0] s_axi_bresp_o,
  output wire s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [3:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output wire s_axi_arready_o,
  output wire [31:0] s_axi_rdata_o,
  output wire [1:0] s_axi_rresp_o,
  output wire s_axi_rvalid_o,
  input wire s_axi_rready_i,
  output reg instr_period_sel_o,
  output reg wdog_enable_o,
  output reg [2:0] osc_mode_o,
  output reg osc_out_clock_o,
  output reg osc_in_pin_gpio_o,
  output reg osc_out_pin_gpio_o,
  output reg power_range_sel_o,
  output reg protect_enable_o,
  output reg int_falling_edge_o,
  output reg [5:0] filter_width_o,
  output reg filter_active_o,
  output reg branch_two_cycles_o,
  output reg [1:0] irc_freq_o,
  output reg [1:0] instr_cycles_o,
  output reg cal_ok_o
);

  // ****************************************************************
  // Option capture
  // ****************************************************************
  reg [12:0] first_q;
  reg [12:0] second_q;
  reg [12:0] id_q;
  reg captured_q;
  wire [2:0] osc;
  wire low_xtal;

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  // Clock driven out on the output pin
  function owd_clk_out;
    input [2:0] mode;
    begin
      case (mode)
        `OWD_OSC_EXT_RC_CK: owd_clk_out = 1'b1;
        `OWD_OSC_INT_RC_CK: owd_clk_out = 1'b1;
        default: owd_clk_out = 1'b0;
      endcase
    end
  endfunction

  // Input pin handed to general I/O in internal RC only
  function owd_in_free;
    input [2:0] mode;
    begin
      case (mode)
        `OWD_OSC_INT_RC_IO: owd_in_free = 1'b1;
        `OWD_OSC_INT_RC_CK: owd_in_free = 1'b1;
        default: owd_in_free = 1'b0;
      endcase
    end
  endfunction

  // Output pin handed to general I/O; crystals never free it
  function owd_out_free;
    input [2:0] mode;
    begin
      case (mode)
        `OWD_OSC_EXT_RC_IO: owd_out_free = 1'b1;
        `OWD_OSC_INT_RC_IO: owd_out_free = 1'b1;
        default: owd_out_free = 1'b0;
      endcase
    end
  endfunction

  // All ones is the only unprotected code
  function owd_prot_on;
    input [2:0] code;
    begin
      owd_prot_on = (code != `OWD_PROT_OFF);
    end
  endfunction

  // Shortest pulse, in oscillator periods, taken as a signal
  function [5:0] owd_fwidth;
    input long_sel;
    begin
      if (long_sel)
        owd_fwidth = `OWD_FWIDTH_LONG;
      else
        owd_fwidth = `OWD_FWIDTH_SHORT;
    end
  endfunction

  // Low crystal and sleep override the enable bit
  function owd_filter_on;
    input enable;
    input xtal_low;
    input asleep;
    begin
      owd_filter_on = enable & ~xtal_low & ~asleep;
    end
  endfunction

  // Only program counter writes stretch to two cycles
  function [1:0] owd_cycles;
    input pc_wr;
    input two_sel;
    begin
      if (pc_wr && two_sel)
        owd_cycles = 2'h2;
      else
        owd_cycles = 2'h1;
    end
  endfunction

  // R18: capture under reset
  // R1: three 13-bit words
  // R2: bits 12..10 of first and 12..9 of second forced to one
  always @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      first_q <= first_word_i | `OWD_FIRST_FILL;
      second_q <= second_word_i | `OWD_SECOND_FILL;
      id_q <= id_word_i;
      captured_q <= 1'b0;
    end
    else
      captured_q <= 1'b1;
  end

  assign osc = first_q[`OWD_F_OSC_HI:`OWD_F_OSC_LO];
  assign low_xtal = (osc == `OWD_OSC_LOW_XTAL);

  // ****************************************************************
  // Decoded settings
  // ****************************************************************
  always @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      instr_period_sel_o <= 1'b1;
      wdog_enable_o <= 1'b0;
      osc_mode_o <= `OWD_OSC_HIGH_XTAL;
      osc_out_clock_o <= 1'b0;
      osc_in_pin_gpio_o <= 1'b0;
      osc_out_pin_gpio_o <= 1'b0;
      power_range_sel_o <= 1'b0;
      protect_enable_o <= 1'b1;
      int_falling_edge_o <= 1'b1;
      filter_width_o <= `OWD_FWIDTH_LONG;
      filter_active_o <= 1'b0;
      branch_two_cycles_o <= 1'b1;
      irc_freq_o <= 2'h3;
      instr_cycles_o <= 2'h1;
      cal_ok_o <= 1'b1;
    end
    else
    begin
      // R3: instruction period
      instr_period_sel_o <= first_q[`OWD_F_PERIOD];
      // R4: inverted watchdog gate
      wdog_enable_o <= ~first_q[`OWD_F_WDOG];
      // R5: oscillator mode
      osc_mode_o <= osc;
      osc_out_clock_o <= owd_clk_out(osc);
      // R6: input pin free only for internal RC
      // R7: crystal keeps both pins
      osc_in_pin_gpio_o <= owd_in_free(osc);
      osc_out_pin_gpio_o <= owd_out_free(osc);
      // R8: power range
      power_range_sel_o <= first_q[`OWD_F_POWER];
      // R9: protect unless all ones
      protect_enable_o <= owd_prot_on(first_q[`OWD_F_PROT_HI:0]);
      // R10: falling edge trigger
      int_falling_edge_o <= 1'b1;
      // R11: filter pulse width
      filter_width_o <= owd_fwidth(second_q[`OWD_F_FWIDTH]);
      // R12: filter enable
      // R13: forced off in low crystal or sleep
      filter_active_o <= owd_filter_on(second_q[`OWD_F_FEN], low_xtal,
                                       sleep_i);
      // R14: cycle count selection
      branch_two_cycles_o <= second_q[`OWD_F_BRANCH];
      // R17: only program counter writes stretch
      instr_cycles_o <= owd_cycles(pc_write_i, second_q[`OWD_F_BRANCH]);
      // R16: internal RC frequency code
      irc_freq_o <= second_q[`OWD_F_IRC_HI:0];
      // R15: calibration bits expected all ones
      cal_ok_o <= &second_q[`OWD_F_CAL_HI:`OWD_F_CAL_LO];
    end
  end

  // ****************************************************************
  // AXI4-Lite slave, read only
  // ****************************************************************
  reg bvalid_q;
  reg [1:0] bresp_q;
  reg rvalid_q;
  reg [1:0] rresp_q;
  reg [31:0] rdata_q;
  reg [31:0] rdata_d;
  reg rerr_d;
  wire wr_go;
  wire [5:0] status_bits;

  assign wr_go = s_axi_awvalid_i & s_axi_wvalid_i & ~bvalid_q;
  assign s_axi_awready_o = wr_go;
  assign s_axi_wready_o = wr_go;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;
  assign s_axi_arready_o = ~rvalid_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rresp_o = rresp_q;
  assign s_axi_rdata_o = rdata_q;
  // Captured sits in bit 0 so software can poll a single bit
  assign status_bits = {filter_active_o,
                        cal_ok_o,
                        protect_enable_o,
                        wdog_enable_o,
                        osc_in_pin_gpio_o,
                        captured_q};

  always @*
  begin
    rdata_d = 32'h0;
    rerr_d = 1'b0;
    case (s_axi_araddr_i)
      `OWD_OFF_FIRST: rdata_d = {19'h0, first_q};
      `OWD_OFF_SECOND: rdata_d = {19'h0, second_q};
      `OWD_OFF_STATUS: rdata_d = {19'h0, id_q};
      `OWD_OFF_CTRL: rdata_d = {26'h0, status_bits};
      default: rerr_d = 1'b1;
    endcase
  end

  // Writes ignored: settings must not change after reset
  always @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= `OWD_RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= `OWD_RESP_OKAY;
      rdata_q <= 32'h0;
    end
    else
    begin
      if (wr_go)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= `OWD_RESP_SLVERR;
      end
      else if (s_axi_bready_i)
        bvalid_q <= 1'b0;
      if (s_axi_arvalid_i && !rvalid_q)
      begin
        rvalid_q <= 1'b1;
        rdata_q <= rdata_d;
        rresp_q <= rerr_d ? `OWD_RESP_SLVERR : `OWD_RESP_OKAY;
      end
      else if (s_axi_rready_i)
        rvalid_q <= 1'b0;
    end
  end

endmodule // owd_option_decoder

// ### tb/owd_checker_assertions.sv
// Purpose: Assertions on the option word decoder ports
// Assumes: Option words are sampled while reset is low
// Notes: Settings lag sleep and PC write by one cycle
`timescale 1ns/100ps
module owd_checker
(
  input wire core_clk_i,
  input wire rstn_i,
  input wire [12:0] first_word_i,
  input wire [12:0] second_word_i,
  input wire sleep_i,
  input wire pc_write_i,
  input wire wdog_enable_o,
  input wire [2:0] osc_mode_o,
  input wire osc_in_pin_gpio_o,
  input wire osc_out_pin_gpio_o,
  input wire protect_enable_o,
  input wire filter_active_o,
  input wire [1:0] instr_cycles_o
);
  reg [12:0] w0_q;
  reg [12:0] w1_q;
  // Later word changes must not reach the settings
  always @(posedge core_clk_i)
    if (!rstn_i)
      {w0_q, w1_q} <= {first_word_i, second_word_i};
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  chk_wdog_sense: assert property ($past(rstn_i) |->
    wdog_enable_o == !w0_q[7]) else $error("wdog");
  chk_osc_mode: assert property ($past(rstn_i) |->
    osc_mode_o == w0_q[6:4]) else $error("osc mode");
  chk_protect_code: assert property ($past(rstn_i) |->
    protect_enable_o == (w0_q[2:0] != 3'h7)) else $error("protect");
  chk_crystal_pins: assert property (osc_mode_o[2] |->
    !osc_in_pin_gpio_o && !osc_out_pin_gpio_o) else $error("xtal pins");
  chk_irc_input: assert property ($past(rstn_i) |->
    osc_in_pin_gpio_o == (w0_q[6:5] == 2'h1)) else $error("osc in");
  chk_filter_off: assert property ($past(sleep_i) ||
    osc_mode_o == 3'h6 |-> !filter_active_o) else $error("filt off");
  chk_filter_on: assert property ($past(rstn_i) && !$past(sleep_i) |->
    filter_active_o == (w1_q[7] && w0_q[6:4] != 3'h6)) else $error("filt");
  chk_branch_cycles: assert property ($past(rstn_i) |->
    instr_cycles_o == ($past(pc_write_i) && w1_q[6] ? 2'h2 : 2'h1))
    else $error("cycles");
endmodule // owd_checker
bind owd_option_decoder owd_checker i_chk (.*);

// ### tb/tb_top.sv
// Purpose: Self-checking bench for the option word decoder
// Assumes: Settings are read three cycles after reset release
// Notes: One table row per oscillator mode
`timescale 1ns/100ps
module tb_top;
  logic core_clk_i, rstn_i, sleep_i, pc_write_i, s_axi_awvalid_i;
  logic s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i;
  logic [3:0] s_axi_awaddr_i, s_axi_araddr_i, s_axi_wstrb_i;
  logic [31:0] s_axi_wdata_i;
  logic [12:0] first_word_i, second_word_i, id_word_i, w0, w1;
  logic [14:0] ex;
  wire s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
  wire s_axi_rvalid_o, instr_period_sel_o, wdog_enable_o, osc_out_clock_o;
  wire osc_in_pin_gpio_o, osc_out_pin_gpio_o, power_range_sel_o, cal_ok_o;
  wire protect_enable_o, int_falling_edge_o, filter_active_o;
  wire branch_two_cycles_o;
  wire [1:0] s_axi_bresp_o, s_axi_rresp_o, irc_freq_o, instr_cycles_o;
  wire [2:0] osc_mode_o;
  wire [5:0] filter_width_o;
  wire [31:0] s_axi_rdata_o;
  wire [14:0] sett = {filter_active_o, instr_period_sel_o, wdog_enable_o,
    osc_mode_o, osc_in_pin_gpio_o, osc_out_pin_gpio_o, power_range_sel_o,
    protect_enable_o, filter_width_o[5], branch_two_cycles_o, irc_freq_o,
    cal_ok_o};
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  // Rows: first word, second word, expected settings
  // cal bits kept at one except row two, which trips cal_ok
  logic [40:0] rows [6] = '{{13'h0, 13'hbc, 15'h50a1},
    {13'h19f, 13'h141, 15'h225a}, {13'h26, 13'h3e, 15'h15a5},
    {13'h33, 13'hbf, 15'h5727}, {13'h64, 13'h1ff, 15'h1c3f},
    {13'h1fff, 13'h1fff, 15'h6e5f}};
  owd_option_decoder i_dut (.*);
  always #10 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i)
    if (++cyc == 1000)
    begin
      fail_count++;
      test_done;
    end
  task chk(input logic [31:0] g, e);
    begin
      check_count++;
      if (g !== e)
      begin
        fail_count++;
        $display("BAD %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task test_done;
    begin
      $display("checks %0d fails %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] r);
    begin
      s_axi_araddr_i <= a;
      {s_axi_arvalid_i, s_axi_rready_i} <= 2'h3;
      do @(posedge core_clk_i); while (s_axi_arready_o !== 1'h1);
      s_axi_arvalid_i <= 1'h0;
      do @(posedge core_clk_i); while (s_axi_rvalid_o !== 1'h1);
      chk(s_axi_rdata_o, e);
      chk(s_axi_rresp_o, r);
      s_axi_rready_i <= 1'h0;
      @(posedge core_clk_i);
    end
  endtask
  initial
  begin
    core_clk_i = 1'h0;
    {rstn_i, sleep_i, pc_write_i, s_axi_awvalid_i, s_axi_wvalid_i} = 5'h0;
    {s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = 3'h0;
    {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wstrb_i} = 12'h00f;
    {s_axi_wdata_i, id_word_i} = {32'h0, 13'h0a5c};
    for (int i = 0; i < 6; i++)
    begin
      {w0, w1, ex} = rows[i];
      {first_word_i, second_word_i, rstn_i} <= {w0, w1, 1'h0};
      repeat (i ? 2 : 4) @(posedge core_clk_i);
      chk(sett, 15'h2e3f);
      rstn_i <= 1'h1;
      repeat (2) @(posedge core_clk_i);
      // Words move after release; settings must not
      {first_word_i, second_word_i} <= {~w0, ~w1};
      @(posedge core_clk_i);
      chk(sett, ex);
      chk(osc_out_clock_o, w0[6:4] == 3'h1 || w0[6:4] == 3'h3);
      chk(filter_width_o, w1[8] ? 6'h20 : 6'h08);
      rd(4'h0, {19'h0, w0 | 13'h1c00}, 2'h0);
      rd(4'h4, {19'h0, w1 | 13'h1e00}, 2'h0);
    end
    {sleep_i, pc_write_i} <= 2'h3;
    repeat (2) @(posedge core_clk_i);
    chk(filter_active_o, 1'h0);
    chk(instr_cycles_o, 2'h2);
    chk(int_falling_edge_o, 1'h1);
    {sleep_i, pc_write_i} <= 2'h0;
    repeat (2) @(posedge core_clk_i);
    chk(filter_active_o, 1'h1);
    chk(instr_cycles_o, 2'h1);
    rd(4'h8, 32'h0a5c, 2'h0);
    rd(4'hc, 32'h31, 2'h0);
    rd(4'h2, 32'h0, 2'h2);
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'h7;
    do @(posedge core_clk_i); while (s_axi_awready_o !== 1'h1);
    {s_axi_awvalid_i, s_axi_wvalid_i} <= 2'h0;
    do @(posedge core_clk_i); while (s_axi_bvalid_o !== 1'h1);
    chk(s_axi_bresp_o, 2'h2);
    s_axi_bready_i <= 1'h0;
    rd(4'h0, 32'h1fff, 2'h0);
    test_done;
  end
endmodule // tb_top
